// >>> spg_regs.svh
// Register offsets, fields, reset values and timing counts for spg
`ifndef SPG_REGS_SVH
`define SPG_REGS_SVH
`define SPG_ADDR_W          4
`define SPG_OFF_SLEEP_CTRL  4'h0
`define SPG_OFF_CLK_GATE    4'h1
`define SPG_OFF_BO_CTRL     4'h2
`define SPG_OFF_STATUS      4'h3
`define SPG_OFF_CLK_SRC     4'h4
`define SPG_BIT_MODE_HI     6
`define SPG_BIT_ARM         5
`define SPG_BIT_MODE_LO     4
`define SPG_BIT_OFF         1
`define SPG_BIT_UNLOCK      0
`define SPG_BIT_T16         3
`define SPG_BIT_T8          2
`define SPG_BIT_USI         1
`define SPG_BIT_UART        0
`define SPG_GATE_MASK       8'h0F
`define SPG_RST_BYTE        8'h00
`define SPG_UNLOCK_WIN      3'h4
`define SPG_OFFBIT_DELAY    3'h3
`define SPG_OFFBIT_HOLD     3'h3
`define SPG_STBY_WAKE       8'h06
`define SPG_WAKE_EXTRA      8'h04
`define SPG_CLK_MHZ         20
`define SPG_BO_WAKE_US      60
`define SPG_BO_WAKE_CYC     ((`SPG_BO_WAKE_US) * (`SPG_CLK_MHZ))
`define SPG_CNT_W           12
`define SPG_ONE_CNT         12'h001
`define SPG_ZERO_CNT        12'h000
`endif

// >>> spg_pkg.sv
// Types shared by the sleep and power gating controller
package spg_pkg;
  typedef enum logic [1:0] {
    SPG_ACTIVE,
    SPG_IDLE,
    SPG_PDOWN,
    SPG_STBY
  } spg_mode_t;
  typedef enum logic [1:0] {
    SPG_RUN,
    SPG_ASLEEP,
    SPG_WAKING
  } spg_state_t;
endpackage

// >>> spg_periph_gate.sv
// One peripheral clock enable and register access gate
`timescale 1ns/100ps
`include "spg_regs.svh"
module spg_periph_gate
  import spg_pkg::*;
(
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic gate_bit,     // Clock gate bit from register
  input  wire logic io_run,       // I/O clock domain running
  output logic      clk_en,       // Peripheral clock enable
  output logic      access_ok     // Peripheral registers accessible
);
  typedef struct packed {
    logic en;
    logic acc;
  } spg_gate_st_t;
  spg_gate_st_t st_reg;           // Registered state
  spg_gate_st_t st_next;          // Next state

  // Enable only when ungated and I/O domain running
  always_comb
  begin
    st_next     = st_reg;
    st_next.en  = ~gate_bit & io_run;
    st_next.acc = ~gate_bit;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign clk_en    = st_reg.en;
  assign access_ok = st_reg.acc;
endmodule // spg_periph_gate

// >>> spg_ctrl.sv
// Sleep mode, brown-out sleep and peripheral clock gating controller
`timescale 1ns/100ps
`include "spg_regs.svh"
module spg_ctrl
  import spg_pkg::*;
(
  input  wire logic                   clk,          // System clock
  input  wire logic                   rst,          // Synchronous reset
  input  wire logic [`SPG_ADDR_W-1:0] reg_addr,     // Register address
  input  wire logic [7:0]             reg_wdata,    // Write data
  input  wire logic                   reg_wr,       // Write strobe
  input  wire logic                   reg_rd,       // Read strobe
  output logic      [7:0]             reg_rdata,    // Read data
  input  wire logic                   sleep_instr,  // CPU sleep pulse
  input  wire logic                   wake_irq,     // Wake interrupt
  input  wire logic                   wake_pin_req, // Pin wake source
  input  wire logic                   comp_uses_ref,// Comparator on bandgap
  input  wire logic [15:0]            start_cycles, // Start-up time, cycles
  output logic                        cpu_clk_en,   // CPU clock enable
  output logic                        flash_clk_en, // Flash clock enable
  output logic                        io_clk_en,    // I/O clock enable
  output logic                        osc_en,       // Main oscillator on
  output logic                        brownout_en,  // Brown-out enable
  output logic                        in_buf_en,    // General inputs on
  output logic                        wake_buf_en,  // Wake pin inputs on
  output logic                        comp_en,      // Comparator enable
  output logic                        t16_clk_en,   // 16-bit timer clock
  output logic                        t8_clk_en,    // 8-bit timer clock
  output logic                        usi_clk_en,   // Univ. serial clock
  output logic                        uart_clk_en,  // Async serial clock
  output logic      [3:0]             periph_acc_ok // Peripheral access
);
  // Whole block state
  typedef struct packed {
    logic [1:0]            sleep_mode_select; // Mode field
    logic                  sleep_arm;         // Arm bit
    logic                  clk_src_xtal;      // Crystal source selected
    logic [3:0]            gate;              // Clock gate bits
    logic                  unlock;            // Unlock bit
    logic [2:0]            unlock_cnt;        // Unlock window count
    logic                  offbit_pend;       // Off bit written
    logic                  brownout_off_in_sleep; // Off bit active
    logic [2:0]            offbit_cnt;        // Off bit phase count
    logic                  bo_was_off;        // Off during this sleep
    spg_state_t            state;             // Sleep sequencer
    spg_mode_t             mode;              // Current mode
    logic [`SPG_CNT_W-1:0] wake_cnt;          // Wake delay count
    logic [7:0]            rdata;             // Read data
    logic                  cpu_en;
    logic                  flash_en;
    logic                  io_en;
    logic                  osc;
    logic                  brownout;
    logic                  inbuf;
    logic                  wakebuf;
    logic                  comp;
  } spg_st_t;
  spg_st_t st_reg;  // Registered state
  spg_st_t st_next; // Next state
  logic [3:0] clk_en_w;   // Per peripheral clock enables
  logic [3:0] acc_w;      // Per peripheral access
  spg_mode_t  sel_mode;   // Decoded requested mode
  logic       deep;       // Power-down or Standby selected
  logic [`SPG_CNT_W-1:0] wake_len; // Wake delay length

  // Mode decode from mode field and clock source
  always_comb
  begin
    case (st_reg.sleep_mode_select)
      2'b00:   sel_mode = SPG_IDLE;
      2'b10:   sel_mode = st_reg.clk_src_xtal ? SPG_STBY
                                              : SPG_PDOWN;
      default: sel_mode = SPG_PDOWN;
    endcase
    deep = (sel_mode == SPG_PDOWN) || (sel_mode == SPG_STBY);
    // Wake length: brown-out stretch, standby, or start-up plus four
    if (st_reg.bo_was_off)
      wake_len = `SPG_CNT_W'(`SPG_BO_WAKE_CYC);
    else if (st_reg.mode == SPG_STBY)
      wake_len = `SPG_CNT_W'(`SPG_STBY_WAKE);
    else
      wake_len = `SPG_CNT_W'(start_cycles)
               + `SPG_CNT_W'(`SPG_WAKE_EXTRA);
  end

  // Registers, unlock sequence, sleep sequencer, clock domains
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = `SPG_RST_BYTE;
    // Unlock window counts down
    if (st_reg.unlock_cnt != 3'h0)
      st_next.unlock_cnt = st_reg.unlock_cnt - 3'h1;
    else
      st_next.unlock = 1'b0;
    // Off bit: delay then active, then self clear
    if (st_reg.offbit_cnt != 3'h0)
      st_next.offbit_cnt = st_reg.offbit_cnt - 3'h1;
    if (st_reg.offbit_pend && st_reg.offbit_cnt == 3'h1)
    begin
      st_next.offbit_pend = 1'b0;
      st_next.brownout_off_in_sleep = 1'b1;
      st_next.offbit_cnt = `SPG_OFFBIT_HOLD;
    end
    else if (st_reg.brownout_off_in_sleep && st_reg.offbit_cnt == 3'h1)
      st_next.brownout_off_in_sleep = 1'b0;
    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `SPG_OFF_SLEEP_CTRL:
        begin
          st_next.sleep_mode_select = {reg_wdata[`SPG_BIT_MODE_HI],
                                       reg_wdata[`SPG_BIT_MODE_LO]};
          st_next.sleep_arm = reg_wdata[`SPG_BIT_ARM];
        end
        `SPG_OFF_CLK_GATE:
          st_next.gate = reg_wdata[3:0];
        `SPG_OFF_BO_CTRL:
        begin
          if (reg_wdata[`SPG_BIT_OFF] && reg_wdata[`SPG_BIT_UNLOCK])
          begin
            st_next.unlock = 1'b1;
            st_next.unlock_cnt = `SPG_UNLOCK_WIN;
          end
          else if (reg_wdata[`SPG_BIT_OFF] && st_reg.unlock)
          begin
            st_next.unlock = 1'b0;
            st_next.unlock_cnt = 3'h0;
            st_next.offbit_pend = 1'b1;
            st_next.offbit_cnt = `SPG_OFFBIT_DELAY;
          end
          else
          begin
            st_next.unlock = 1'b0;
            st_next.unlock_cnt = 3'h0;
          end
        end
        `SPG_OFF_CLK_SRC:
          st_next.clk_src_xtal = reg_wdata[0];
        default: ;
      endcase
    end
    // Register reads, data valid next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        `SPG_OFF_SLEEP_CTRL:
        begin
          st_next.rdata[`SPG_BIT_MODE_HI] = st_reg.sleep_mode_select[1];
          st_next.rdata[`SPG_BIT_MODE_LO] = st_reg.sleep_mode_select[0];
          st_next.rdata[`SPG_BIT_ARM]     = st_reg.sleep_arm;
        end
        `SPG_OFF_CLK_GATE:
          st_next.rdata = {4'h0, st_reg.gate};
        `SPG_OFF_BO_CTRL:
          st_next.rdata = {6'h00, st_reg.brownout_off_in_sleep,
                           st_reg.unlock};
        `SPG_OFF_STATUS:
          st_next.rdata = {3'h0, st_reg.bo_was_off, 2'(st_reg.mode),
                           2'(st_reg.state)};
        `SPG_OFF_CLK_SRC:
          st_next.rdata = {7'h00, st_reg.clk_src_xtal};
        default: st_next.rdata = `SPG_RST_BYTE;
      endcase
    end
    // Sleep sequencer
    case (st_reg.state)
      SPG_RUN:
        if (sleep_instr && st_reg.sleep_arm)
        begin
          st_next.state = SPG_ASLEEP;
          st_next.mode = sel_mode;
          st_next.bo_was_off = deep &&
                                st_reg.brownout_off_in_sleep;
        end
      SPG_ASLEEP:
        if (wake_irq || wake_pin_req)
        begin
          st_next.state = SPG_WAKING;
          st_next.wake_cnt = `SPG_ONE_CNT;
        end
      SPG_WAKING:
        if (st_reg.wake_cnt >= wake_len)
        begin
          st_next.state = SPG_RUN;
          st_next.mode = SPG_ACTIVE;
          st_next.bo_was_off = 1'b0;
          st_next.wake_cnt = `SPG_ZERO_CNT;
        end
        else
          st_next.wake_cnt = st_reg.wake_cnt + `SPG_ONE_CNT;
      default: st_next.state = SPG_RUN;
    endcase
    // Clock domain enables by next mode
    st_next.cpu_en = (st_next.mode == SPG_ACTIVE);
    st_next.flash_en = st_next.cpu_en;
    st_next.io_en = (st_next.mode == SPG_ACTIVE) ||
                    (st_next.mode == SPG_IDLE);
    st_next.osc = (st_next.mode != SPG_PDOWN);
    st_next.brownout = !(st_next.bo_was_off &&
                    st_next.state == SPG_ASLEEP);
    st_next.inbuf = st_next.io_en;
    st_next.wakebuf = 1'b1;
    st_next.comp = st_next.io_en || comp_uses_ref;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.state <= SPG_RUN;
      st_reg.mode <= SPG_ACTIVE;
      st_reg.cpu_en <= 1'b1;
      st_reg.flash_en <= 1'b1;
      st_reg.io_en <= 1'b1;
      st_reg.osc <= 1'b1;
      st_reg.brownout <= 1'b1;
      st_reg.inbuf <= 1'b1;
      st_reg.wakebuf <= 1'b1;
      st_reg.comp <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Per peripheral clock gates
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_gate
      spg_periph_gate u_gate (
        .clk       (clk),
        .rst       (rst),
        .gate_bit  (st_reg.gate[g]),
        .io_run    (st_reg.io_en),
        .clk_en    (clk_en_w[g]),
        .access_ok (acc_w[g])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  assign reg_rdata = st_reg.rdata;
  assign cpu_clk_en = st_reg.cpu_en;
  assign flash_clk_en = st_reg.flash_en;
  assign io_clk_en = st_reg.io_en;
  assign osc_en = st_reg.osc;
  assign brownout_en = st_reg.brownout;
  assign in_buf_en = st_reg.inbuf;
  assign wake_buf_en = st_reg.wakebuf;
  assign comp_en = st_reg.comp;
  assign t16_clk_en = clk_en_w[`SPG_BIT_T16];
  assign t8_clk_en = clk_en_w[`SPG_BIT_T8];
  assign usi_clk_en = clk_en_w[`SPG_BIT_USI];
  assign uart_clk_en = clk_en_w[`SPG_BIT_UART];
  assign periph_acc_ok = acc_w;
endmodule // spg_ctrl

// >>> spg_ctrl_asserts.sv
// Port-level checks for the sleep and power gating controller
`timescale 1ns/100ps
`include "spg_regs.svh"
module spg_ctrl_asserts
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [`SPG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   comp_uses_ref,
  input wire logic                   cpu_clk_en,
  input wire logic                   flash_clk_en,
  input wire logic                   io_clk_en,
  input wire logic                   osc_en,
  input wire logic                   brownout_en,
  input wire logic                   in_buf_en,
  input wire logic                   wake_buf_en,
  input wire logic                   comp_en,
  input wire logic                   t16_clk_en,
  input wire logic [3:0]             periph_acc_ok
);
  // One clock domain, one reset
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read data only in the slot after a read
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_gate_upper: assert property (
    reg_rd && reg_addr == `SPG_OFF_CLK_GATE |=> reg_rdata[7:4] == 4'h0)
    else $error("gate register upper bits not zero");
  a_access_gate: assert property (
    reg_wr && reg_addr == `SPG_OFF_CLK_GATE
    |-> ##3 periph_acc_ok == ~$past(reg_wdata[3:0], 3))
    else $error("peripheral access does not follow gate bits");
  a_cpu_flash: assert property (cpu_clk_en == flash_clk_en)
    else $error("cpu and flash clocks differ");
  a_idle_clocks: assert property (
    !cpu_clk_en && io_clk_en |-> !flash_clk_en && osc_en && comp_en)
    else $error("idle stops more than cpu and flash");
  a_pdown_stop: assert property (
    !osc_en |-> !io_clk_en && !cpu_clk_en)
    else $error("clocks run with oscillator off");
  a_brownout_awake: assert property (
    io_clk_en |-> brownout_en)
    else $error("brown-out off while not in deep sleep");
  a_in_bufs: assert property (
    in_buf_en == io_clk_en && wake_buf_en)
    else $error("input buffers do not follow io clock");
  a_comp_off: assert property (
    !io_clk_en && !$past(io_clk_en) && !comp_uses_ref
    && !$past(comp_uses_ref) |-> !comp_en)
    else $error("comparator on in deep sleep");
  a_periph_stop: assert property (
    !io_clk_en && !$past(io_clk_en) |-> !t16_clk_en)
    else $error("peripheral clock runs in deep sleep");
  // Main scenarios reached
  c_deep: cover property (!osc_en);
  c_brownout_off: cover property (!brownout_en);
  c_idle: cover property (!cpu_clk_en && io_clk_en);
endmodule // spg_ctrl_asserts
bind spg_ctrl spg_ctrl_asserts u_chk (.*);

// >>> test_spg_ctrl.sv
// Self-checking bench for the sleep and power gating controller
`timescale 1ns/100ps
`include "spg_regs.svh"
module test_spg_ctrl;
  logic        clk, rst, reg_wr, reg_rd, sleep_instr, wake_irq;
  logic        wake_pin_req, comp_uses_ref, cpu_clk_en, flash_clk_en;
  logic        io_clk_en, osc_en, brownout_en, in_buf_en, wake_buf_en;
  logic        comp_en, t16_clk_en, t8_clk_en, usi_clk_en, uart_clk_en;
  logic [3:0]  reg_addr, periph_acc_ok, ng;
  logic [7:0]  reg_wdata, reg_rdata, g;
  logic [15:0] start_cycles;
  logic [31:0] seed;
  logic [1:0]  k;
  int          err_count, samples_checked, n, cs;
  // Device under test
  spg_ctrl DUT (.*);
  // 20 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected status mode code: 1 idle, 2 power-down, 3 standby
  function automatic logic [1:0] code(input int m, input int x);
    if (m == 0)
      return 2'h1;
    return (m == 2 && x == 1) ? 2'h3 : 2'h2;
  endfunction
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // Register read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Sleep instruction pulse, then let the state settle
  task automatic nap();
    @(posedge clk) sleep_instr <= 1'h1;
    @(posedge clk) sleep_instr <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Raise a wake request and count cycles to cpu clock return
  task automatic wake(output int c);
    c = 0;
    @(posedge clk) wake_irq <= 1'h1;
    while (cpu_clk_en !== 1'h1 && c < 3000)
    begin
      @(posedge clk);
      #1 c++;
    end
    wake_irq <= 1'h0;
    if (c >= 3000)
      err_count++;
    wr(`SPG_OFF_SLEEP_CTRL, 8'h00);
  endtask
  // Brown-out off sequence, gap edges between the two writes
  task automatic unlock(input int gap);
    wr(`SPG_OFF_BO_CTRL, 8'h03);
    repeat (gap) @(posedge clk);
    wr(`SPG_OFF_BO_CTRL, 8'h02);
    repeat (2) @(posedge clk);
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #(50 * 40000);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    rst = 1'h1;
    {reg_wr, reg_rd, sleep_instr, wake_irq, wake_pin_req} = 5'h00;
    {reg_addr, reg_wdata, comp_uses_ref, cs} = '0;
    start_cycles = 16'h0010;
    seed = 32'h0000_f07b;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(`SPG_OFF_SLEEP_CTRL, 8'h00);
    rd(`SPG_OFF_BO_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    wr(`SPG_OFF_BO_CTRL, 8'h02);
    rd(`SPG_OFF_BO_CTRL, 8'h00);
    // Random gate patterns, ending fully ungated
    for (int i = 0; i < 7; i++)
    begin
      seed = xs(seed);
      g = (i == 6) ? 8'h00 : seed[7:0];
      ng = ~g[3:0];
      wr(`SPG_OFF_CLK_GATE, g);
      rd(`SPG_OFF_CLK_GATE, {4'h0, g[3:0]});
      repeat (3) @(posedge clk);
      #1 chk({t16_clk_en, t8_clk_en, usi_clk_en, uart_clk_en},
             ng);
      chk(periph_acc_ok, ng);
    end
    // Every mode code, with and without a crystal
    for (int x = 1; x >= 0; x--)
      for (int m = 0; m < 4; m++)
      begin
        wr(`SPG_OFF_CLK_SRC, 8'(x));
        seed = xs(seed);
        start_cycles = {11'h000, seed[4:0]} + 16'h0008;
        wr(`SPG_OFF_SLEEP_CTRL, {1'h0, m[1], 1'h1, m[0], 4'h0});
        nap();
        k = code(m, x);
        chk({cpu_clk_en, io_clk_en, osc_en, t16_clk_en},
            {1'h0, k == 1, k != 2, k == 1});
        rd(`SPG_OFF_STATUS, {4'h0, k, 2'h1});
        wake(n);
        if (k == 3)
          cs = n;
        else if (cs != 0)
          chk(16'(n - cs), start_cycles - 16'h0002);
      end
    // Sleep attempt without the arm bit
    wr(`SPG_OFF_SLEEP_CTRL, 8'h10);
    nap();
    chk(cpu_clk_en, 1);
    // Brown-out off in power-down, comparator on reference
    wr(`SPG_OFF_SLEEP_CTRL, 8'h30);
    comp_uses_ref <= 1'h1;
    unlock(0);
    nap();
    chk({brownout_en, comp_en}, 2'h1);
    rd(`SPG_OFF_STATUS, 8'h19);
    wake(n);
    comp_uses_ref <= 1'h0;
    chk(16'(n - cs), 16'(`SPG_BO_WAKE_CYC - 6));
    chk(brownout_en, 1);
    // Late second write leaves the detector on
    wr(`SPG_OFF_SLEEP_CTRL, 8'h30);
    unlock(6);
    nap();
    chk(brownout_en, 1);
    rd(`SPG_OFF_STATUS, 8'h09);
    wake(n);
    tally_and_finish();
  end
endmodule // test_spg_ctrl
